// File: verification/upp_pin_world.sv
// Model of the circuits wired to the nine user pins.
`timescale 1ns/1ps
module upp_pin_world (
  input wire logic clock,
  input wire logic [8:0] pin_out,
  input wire logic [8:0] pin_oe_n,
  input wire logic [8:0] pull_up_en,
  input wire logic [8:0] ext_en,
  input wire logic [8:0] ext_val,
  output logic [8:0] pin_in
);
  logic wobble = 1'b0;

  // A floating pin toggles every cycle so no check can pass on a settled guess.
  always @(posedge clock) begin
    wobble <= ~wobble;
  end

  // The device drives when its enable is low; else the far side, the pull-up or nothing.
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pull_up_en[i]) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = wobble;
      end
    end
  end
endmodule : upp_pin_world

// File: verification/upp_user_pin_port_bench.sv
// Self-checking bench of the user pin port.
`timescale 1ns/1ps
`define CHK(a, b) begin \
  n_compared++; \
  if ((a) !== (b)) begin \
    fail_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, b); \
  end \
end
module upp_user_pin_port_bench;
  logic clock = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, xram_wr = 1'b0;
  logic xram_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, xram_wdata = 8'h00, sfr_rdata;
  logic [7:0] xram_rdata, q;
  logic [15:0] xram_addr = 16'h0000;
  logic [8:0] pin_in, pin_out, pin_oe_n, pull_up_en, ext_en = 9'h000, ext_val = 9'h000;
  logic t0_line, t1_line, i0_line, i1_line;
  logic [3:0] res;
  int fail_count = 0, n_compared = 0;
  assign res = {t0_line, t1_line, i0_line, i1_line};

  upp_user_pin_port dut_u (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .xram_addr(xram_addr), .xram_wr(xram_wr), .xram_rd(xram_rd),
    .xram_wdata(xram_wdata), .xram_rdata(xram_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
    .timer_zero_gate_clock(t0_line), .timer_one_gate_clock(t1_line),
    .int_zero_request(i0_line), .int_one_request(i1_line));
  upp_pin_world world_u (.clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pull_up_en(pull_up_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  // The clock toggles every half period of 20 ns.
  initial begin
    forever #20 clock = ~clock;
  end

  // One bus cycle on either bus; read data is taken once the strobe has been seen.
  task automatic acc(input bit x, input bit w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock) #1;
    if (x) begin
      xram_addr = a;
      xram_wdata = d;
      xram_wr = w;
      xram_rd = !w;
    end else begin
      sfr_addr = a[7:0];
      sfr_wdata = d;
      sfr_wr = w;
      sfr_rd = !w;
    end
    @(posedge clock) #1;
    {sfr_wr, sfr_rd, xram_wr, xram_rd} = 4'h0;
    @(posedge clock) #1;
    q = x ? xram_rdata : sfr_rdata;
  endtask : acc

  // Lets pin changes pass the input filter before anything is judged.
  task automatic settle();
    repeat (8) @(posedge clock);
    #1;
  endtask : settle

  // Everything is an input with pull-up, and no resource is routed, after reset.
  task automatic t_reset();
    `CHK(pin_oe_n, 9'h1ff)
    `CHK(pull_up_en, 9'h1ff)
    `CHK(res, 4'h0)
    acc(0, 0, 16'h0090, 8'h00);
    `CHK(q, 8'hff)
    acc(1, 0, 16'hff93, 8'h00);
    `CHK(q, 8'h00)
    $display("test reset done");
  endtask : t_reset

  // Mixed directions on pins 0 to 7, with the far side driving the inputs.
  task automatic t_dir_data();
    ext_en = 9'h0f0; ext_val = 9'h050;
    acc(0, 1, 16'h0091, 8'hf0);
    acc(0, 1, 16'h0090, 8'ha5);
    `CHK(pin_oe_n, 9'h1f0)
    `CHK(pull_up_en, 9'h100)
    `CHK(pin_out[7:0], 8'ha5)
    settle();
    acc(0, 0, 16'h0090, 8'h00);
    `CHK(q, 8'h55)
    acc(0, 0, 16'h0091, 8'h00);
    `CHK(q, 8'hf0)
    acc(0, 0, 16'h0092, 8'h00);
    `CHK(q, 8'h00)
    $display("test direction data done");
  endtask : t_dir_data

  // Pin 8 has its own direction and data bit and no routing.
  task automatic t_pin8();
    acc(0, 1, 16'h00a1, 8'hfe);
    acc(0, 1, 16'h00a0, 8'hff);
    `CHK(({pin_oe_n[8], pull_up_en[8], pin_out[8]}), 3'h1)
    settle();
    acc(0, 0, 16'h00a0, 8'h00);
    `CHK(q, 8'h01)
    acc(0, 0, 16'h00a1, 8'h00);
    `CHK(q, 8'h00)
    `CHK(res, 4'h0)
    $display("test pin eight done");
  endtask : t_pin8

  // Every select code on pin 0, at the active and then the idle pin level.
  task automatic t_codes();
    logic [3:0] e;
    ext_en = 9'h0ff; ext_val = 9'h000;
    acc(0, 1, 16'h0091, 8'hff);
    for (int c = 0; c < 8; c++) begin
      e = (c < 2) ? 4'h0 : (c == 2) ? 4'h8 : (c == 3) ? 4'h4 : (c[0] ? 4'h1 : 4'h2);
      acc(1, 1, 16'hff90, 8'(c));
      ext_val[0] = (c < 6);
      settle();
      `CHK(res, e)
      ext_val[0] = (c >= 6);
      settle();
      `CHK(res, 4'h0)
    end
    `CHK(pin_oe_n[0], 1'b1)
    $display("test select codes done");
  endtask : t_codes

  // Two pins on timer zero combine by OR; unused field bits read as zero.
  task automatic t_or();
    acc(1, 1, 16'hff91, 8'hff);
    acc(1, 0, 16'hff91, 8'h00);
    `CHK(q, 8'h77)
    acc(1, 1, 16'hff90, 8'h02);
    acc(1, 1, 16'hff91, 8'h20);
    ext_val = 9'h008;
    settle();
    `CHK(res, 4'h8)
    ext_val = 9'h001;
    settle();
    `CHK(res, 4'h8)
    ext_val = 9'h000;
    settle();
    `CHK(res, 4'h0)
    $display("test combine done");
  endtask : t_or

  // A reset in mid-run must bring back inputs, pull-ups and a quiet routing.
  task automatic t_rereset();
    @(posedge clock) #1;
    rst_n = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    `CHK(pull_up_en, 9'h1ff)
    rst_n = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    `CHK(pin_oe_n, 9'h1ff)
    `CHK(pull_up_en, 9'h1ff)
    `CHK(pin_out, 9'h000)
    `CHK(res, 4'h0)
    $display("test reset again done");
  endtask : t_rereset

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // The tests need under a thousand cycles; this cuts a hang short.
  initial begin
    #400000;
    fail_count++;
    end_sim();
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    t_reset();
    t_dir_data();
    t_pin8();
    t_codes();
    t_or();
    t_rereset();
    end_sim();
  end
endmodule : upp_user_pin_port_bench

// File: verilog/upp_pin_sync.sv
// Three-stage pin input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module upp_pin_sync (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic level
);
  logic stage1;
  logic stage2;
  logic stage3;

  // Stage one feeds only stage two, so a metastable value never reaches the compare.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
      stage3 <= 1'b1;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // The level follows only when the two settled stages agree; idle high matches the pull-up.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b1;
    end else if (stage2 == stage3) begin
      level <= stage3;
    end
  end
endmodule : upp_pin_sync

// File: verilog/upp_pkg.sv
// Package with register offsets, field positions, reset values and select codes.
package upp_pkg;
  // Pin counts and select field width.
  localparam int unsigned NUM_PINS = 9;
  localparam int unsigned NUM_ROUTED = 8;
  localparam int unsigned SEL_W = 3;

  // Special function register offsets.
  localparam logic [7:0] PINS_0_7_DATA = 8'h90;
  localparam logic [7:0] PINS_0_7_DIRECTION = 8'h91;
  localparam logic [7:0] PIN_8_DATA = 8'ha0;
  localparam logic [7:0] PIN_8_DIRECTION = 8'ha1;

  // Extended register offsets of the four resource select registers.
  localparam logic [15:0] PINS_0_1_RESOURCE_SELECT = 16'hff90;
  localparam logic [15:0] PINS_2_3_RESOURCE_SELECT = 16'hff91;
  localparam logic [15:0] PINS_4_5_RESOURCE_SELECT = 16'hff92;
  localparam logic [15:0] PINS_6_7_RESOURCE_SELECT = 16'hff93;

  // Field positions inside a resource select register.
  localparam int unsigned EVEN_FIELD_LSB = 0;
  localparam int unsigned ODD_FIELD_LSB = 4;

  // Reset values.
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] DIRECTION_RESET = 8'hff;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [7:0] PULL_UP_RESET = 8'hff;

  // Resource select codes; 0 and 1 route nowhere.
  localparam logic [2:0] SEL_TIMER_ZERO = 3'h2;
  localparam logic [2:0] SEL_TIMER_ONE = 3'h3;
  localparam logic [2:0] SEL_INT_ZERO_HIGH = 3'h4;
  localparam logic [2:0] SEL_INT_ONE_HIGH = 3'h5;
  localparam logic [2:0] SEL_INT_ZERO_LOW = 3'h6;
  localparam logic [2:0] SEL_INT_ONE_LOW = 3'h7;
endpackage : upp_pkg

// File: verilog/upp_user_pin_port.sv
// User pin port: nine pins with direction, data, pull-up and resource routing.
//
// Operation
// - nine user pins, each general digital I/O.
// - all pins are inputs after reset.
// - every pin has its own direction bit.
// - direction 0 drives output, 1 input.
// - pull-up held until direction register written.
// - data via 8-bit register plus pin-8 bit.
// - pins 0-7 multi-use, pin 8 plain.
// - 3-bit select fields, two per register.
// - select codes map to timers and interrupts.
// - pins on one resource are ORed.
// - edge or level set by timer control.
// - each routed pin GPIO or one resource.
`timescale 1ns/1ps
module upp_user_pin_port (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [15:0] xram_addr,
  input wire logic xram_wr,
  input wire logic xram_rd,
  input wire logic [7:0] xram_wdata,
  output logic [7:0] xram_rdata,
  input wire logic [8:0] pin_in,
  output logic [8:0] pin_out,
  output logic [8:0] pin_oe_n,
  output logic [8:0] pull_up_en,
  output logic timer_zero_gate_clock,
  output logic timer_one_gate_clock,
  output logic int_zero_request,
  output logic int_one_request
);
  logic rst_meta_n;
  logic rst_sync_n;
  logic [7:0] data_lo;
  logic data_hi;
  logic [7:0] dir_lo;
  logic dir_hi;
  logic [7:0] pull_lo;
  logic pull_hi;
  logic [7:0] select_reg [4];
  logic [8:0] pin_level;
  logic [2:0] pin_sel [8];
  logic [7:0] hit_t0;
  logic [7:0] hit_t1;
  logic [7:0] hit_i0;
  logic [7:0] hit_i1;
  logic wr_data_lo;
  logic wr_dir_lo;
  logic wr_data_hi;
  logic wr_dir_hi;
  logic [7:0] next_sfr_rdata;
  logic [7:0] next_xram_rdata;

  // Reset is asserted at once and released through two flops to avoid a ragged release.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // One synchroniser per pin, since every pin arrives from outside the clock domain.
  for (genvar p = 0; p < upp_pkg::NUM_PINS; p++) begin : g_sync
    upp_pin_sync u_sync (
      .clock(clock),
      .rst_n(rst_sync_n),
      .pin_in(pin_in[p]),
      .level(pin_level[p])
    );
  end

  // Write strobes of the special function registers.
  assign wr_data_lo = sfr_wr && (sfr_addr == upp_pkg::PINS_0_7_DATA);
  assign wr_dir_lo = sfr_wr && (sfr_addr == upp_pkg::PINS_0_7_DIRECTION);
  assign wr_data_hi = sfr_wr && (sfr_addr == upp_pkg::PIN_8_DATA);
  assign wr_dir_hi = sfr_wr && (sfr_addr == upp_pkg::PIN_8_DIRECTION);

  // Data registers hold the drive levels; they act on a pin only while it is an output.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      data_lo <= upp_pkg::DATA_RESET;
      data_hi <= 1'b0;
    end else begin
      if (wr_data_lo) begin
        data_lo <= sfr_wdata;
      end
      if (wr_data_hi) begin
        data_hi <= sfr_wdata[0];
      end
    end
  end

  // Direction bits start as inputs; 0 drives the pin, 1 releases it.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dir_lo <= upp_pkg::DIRECTION_RESET;
      dir_hi <= 1'b1;
    end else begin
      if (wr_dir_lo) begin
        dir_lo <= sfr_wdata;
      end
      if (wr_dir_hi) begin
        dir_hi <= sfr_wdata[0];
      end
    end
  end

  // Pull-ups drop on the first direction write to the covering register and return only on reset.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pull_lo <= upp_pkg::PULL_UP_RESET;
      pull_hi <= 1'b1;
    end else begin
      if (wr_dir_lo) begin
        pull_lo <= 8'h00;
      end
      if (wr_dir_hi) begin
        pull_hi <= 1'b0;
      end
    end
  end

  // Resource select registers; bits 7 and 3 are not stored and read as zero.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int r = 0; r < 4; r++) begin
        select_reg[r] <= upp_pkg::SELECT_RESET;
      end
    end else if (xram_wr && (xram_addr[15:2] == upp_pkg::PINS_0_1_RESOURCE_SELECT[15:2])) begin
      select_reg[xram_addr[1:0]] <= xram_wdata & 8'h77;
    end
  end

  // Unpack the per-pin fields, even pin low and odd pin high.
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      pin_sel[k] = select_reg[k / 2][((k % 2 == 0) ? upp_pkg::EVEN_FIELD_LSB
        : upp_pkg::ODD_FIELD_LSB) +: upp_pkg::SEL_W];
    end
  end

  // Only pins 0 to 7 have a field, so pin 8 can never reach a resource.
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      hit_t0[k] = pin_level[k] && (pin_sel[k] == upp_pkg::SEL_TIMER_ZERO);
      hit_t1[k] = pin_level[k] && (pin_sel[k] == upp_pkg::SEL_TIMER_ONE);
      hit_i0[k] = (pin_level[k] && (pin_sel[k] == upp_pkg::SEL_INT_ZERO_HIGH))
        || (!pin_level[k] && (pin_sel[k] == upp_pkg::SEL_INT_ZERO_LOW));
      hit_i1[k] = (pin_level[k] && (pin_sel[k] == upp_pkg::SEL_INT_ONE_HIGH))
        || (!pin_level[k] && (pin_sel[k] == upp_pkg::SEL_INT_ONE_LOW));
    end
  end

  // Resource lines are ORs of all routed pins; inverted pins are folded in so the
  // line is active high. Edge or level detection is left to the timer control logic.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      timer_zero_gate_clock <= 1'b0;
      timer_one_gate_clock <= 1'b0;
      int_zero_request <= 1'b0;
      int_one_request <= 1'b0;
    end else begin
      timer_zero_gate_clock <= |hit_t0;
      timer_one_gate_clock <= |hit_t1;
      int_zero_request <= |hit_i0;
      int_one_request <= |hit_i1;
    end
  end

  // Pin drive comes straight from the data and direction flops, whatever the routing.
  assign pin_out = {data_hi, data_lo};
  assign pin_oe_n = {dir_hi, dir_lo};
  assign pull_up_en = {pull_hi, pull_lo};

  // Read multiplexers; data reads return the live pin level, not the stored drive value.
  always_comb begin
    next_sfr_rdata = 8'h00;
    unique case (sfr_addr)
      upp_pkg::PINS_0_7_DATA: next_sfr_rdata = pin_level[7:0];
      upp_pkg::PINS_0_7_DIRECTION: next_sfr_rdata = dir_lo;
      upp_pkg::PIN_8_DATA: next_sfr_rdata = {7'h00, pin_level[8]};
      upp_pkg::PIN_8_DIRECTION: next_sfr_rdata = {7'h00, dir_hi};
      default: next_sfr_rdata = 8'h00;
    endcase
    next_xram_rdata = 8'h00;
    if (xram_addr[15:2] == upp_pkg::PINS_0_1_RESOURCE_SELECT[15:2]) begin
      next_xram_rdata = select_reg[xram_addr[1:0]];
    end
  end

  // Read data registers; they hold their value between reads.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sfr_rdata <= 8'h00;
      xram_rdata <= 8'h00;
    end else begin
      if (sfr_rd) begin
        sfr_rdata <= next_sfr_rdata;
      end
      if (xram_rd) begin
        xram_rdata <= next_xram_rdata;
      end
    end
  end

  // Checks of the documented behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n);

  dir_write_lo_a: assert property (wr_dir_lo |=> pin_oe_n[7:0] == $past(sfr_wdata))
    else $error("Direction write for pins 0 to 7 not applied.");

  dir_write_hi_a: assert property (wr_dir_hi |=> pin_oe_n[8] == $past(sfr_wdata[0]))
    else $error("Direction write for pin 8 not applied.");

  pullup_clear_a: assert property (wr_dir_lo |=> (pull_up_en[7:0] == 8'h00) [*3])
    else $error("Pull-ups not released after direction write.");

  pullup_input_a: assert property (pull_up_en[0] |-> pin_oe_n[0] && !$past(wr_dir_lo))
    else $error("Pulled-up pin is not an undisturbed input.");

  data_write_a: assert property (wr_data_lo |=> pin_out[7:0] == $past(sfr_wdata))
    else $error("Data write for pins 0 to 7 not applied.");

  read_level_a: assert property ((sfr_rd && sfr_addr == upp_pkg::PIN_8_DATA)
    |=> sfr_rdata == {7'h00, $past(pin_level[8])})
    else $error("Pin 8 read does not return the pin level.");

  timer_or_a: assert property ((pin_sel[0] == upp_pkg::SEL_TIMER_ZERO && pin_level[0])
    || (pin_sel[3] == upp_pkg::SEL_TIMER_ZERO && pin_level[3]) |=> timer_zero_gate_clock)
    else $error("Timer zero line is not the OR of its pins.");

  int_low_a: assert property ((pin_sel[0] == upp_pkg::SEL_INT_ONE_LOW && !pin_level[0])
    |=> int_one_request)
    else $error("Low pin routed to interrupt one not seen.");

  route_keep_a: assert property ((xram_wr && !sfr_wr)
    |=> $stable(pin_oe_n) && $stable(pin_out))
    else $error("Routing write disturbed pin drive.");

  // Pin 8 keeps its own direction and pull-up, apart from the low group.
  dir_hi_keep_a: assert property (wr_dir_lo
    |=> $stable(pin_oe_n[8]))
    else $error("Low direction write moved pin 8.");

  pullup_hi_a: assert property (wr_dir_hi
    |=> !pull_up_en[8])
    else $error("Pin 8 pull-up not released after direction write.");

  pullup_stay_a: assert property (!pull_up_en[8]
    |=> !pull_up_en[8])
    else $error("Pin 8 pull-up came back without a reset.");

  reset_state_a: assert property ($rose(rst_sync_n)
    |-> pin_oe_n == {1'b1, upp_pkg::DIRECTION_RESET}
      && pull_up_en == {1'b1, upp_pkg::PULL_UP_RESET})
    else $error("Pins are not pulled-up inputs after reset.");

  data_write_hi_a: assert property (wr_data_hi
    |=> pin_out[8] == $past(sfr_wdata[0]))
    else $error("Data write for pin 8 not applied.");

  // Read path; read data must stand until the next read strobe.
  read_level_lo_a: assert property ((sfr_rd && sfr_addr == upp_pkg::PINS_0_7_DATA)
    |=> sfr_rdata == $past(pin_level[7:0]))
    else $error("Pins 0 to 7 read does not return the pin levels.");

  rdata_hold_a: assert property (!sfr_rd
    |=> $stable(sfr_rdata))
    else $error("Register read data changed without a read.");

  select_mask_a: assert property (xram_rd
    && xram_addr[15:2] == upp_pkg::PINS_0_1_RESOURCE_SELECT[15:2]
    |=> (xram_rdata & 8'h88) == 8'h00)
    else $error("Unused select bits read back as one.");

  // Select fields land in the right pin and route that pin to its resource.
  sel_write_even_a: assert property (xram_wr
    && xram_addr == upp_pkg::PINS_0_1_RESOURCE_SELECT
    |=> pin_sel[0] == $past(xram_wdata[2:0]))
    else $error("Even pin select write not applied.");

  sel_write_odd_a: assert property (xram_wr
    && xram_addr == upp_pkg::PINS_2_3_RESOURCE_SELECT
    |=> pin_sel[3] == $past(xram_wdata[6:4]))
    else $error("Odd pin select write not applied.");

  timer_one_a: assert property (pin_level[0]
    && pin_sel[0] == upp_pkg::SEL_TIMER_ONE |=> timer_one_gate_clock)
    else $error("High pin routed to timer one not seen.");

  int_zero_high_a: assert property (pin_level[0]
    && pin_sel[0] == upp_pkg::SEL_INT_ZERO_HIGH |=> int_zero_request)
    else $error("High pin routed to interrupt zero not seen.");

  int_one_high_a: assert property (pin_level[0]
    && pin_sel[0] == upp_pkg::SEL_INT_ONE_HIGH |=> int_one_request)
    else $error("High pin routed to interrupt one not seen.");

  cover_dir_c: cover property (wr_dir_lo ##1 pin_oe_n[0] == 1'b0);
  cover_t1_c: cover property (timer_one_gate_clock);
  cover_i0_c: cover property (int_zero_request ##1 !int_zero_request);
  cover_pin8_c: cover property (wr_dir_hi ##1 wr_data_hi);
  cover_or_c: cover property (timer_zero_gate_clock && pin_sel[3] == upp_pkg::SEL_TIMER_ZERO);
endmodule : upp_user_pin_port
